/* File: flash_lock_consts.svh */
// Constants for the flash lock and security block
`ifndef FLASH_LOCK_CONSTS_SVH
`define FLASH_LOCK_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CMD       12'h000
`define OFS_MODE      12'h004
`define OFS_STATUS    12'h008
`define OFS_MASK      12'h00c
`define OFS_NVSTATE   12'h010
`define OFS_ACCESS    12'h014

// ==========================================================
// Command word fields
`define CMD_OP_LSB     0
`define CMD_OP_MSB     3
`define CMD_ARG_LSB    8
`define CMD_ARG_MSB    15
`define CMD_PAGE_LSB   8
`define CMD_PAGE_MSB   15

// ==========================================================
// Geometry
`define NUM_REGIONS    8
`define REGION_PAGES   32
`define PAGE_BYTES     64
`define PAGE_BITS      8
`define REGION_SHIFT   5
`define REGION_BITS    3
`define NUM_GP_BITS    2

// ==========================================================
// Mode / status / nonvolatile bit positions
`define MODE_LOCK_ERROR_FLAG_EN  0
`define ST_LOCK_ERROR_FLAG       0
`define ST_DONE        1
`define ST_ERASED      2
`define NV_SEC         8
`define NV_GP_LSB      9

// ==========================================================
// Erase pin timing (ms, clock in kHz)
`define ERASE_MIN_MS   50
`define SYS_CLK_KHZ    10000
`define ERASE_CNT_W    20

`endif

/* File: flash_lock_pkg.sv */
// Types for the flash lock and security block
package flash_lock_pkg;

  // Flash controller command codes
  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_PROG       = 4'h1,
    CMD_ERASE_PAGE = 4'h2,
    CMD_SET_LOCK   = 4'h3,
    CMD_CLR_LOCK   = 4'h4,
    CMD_ERASE_ALL  = 4'h5,
    CMD_SET_SEC    = 4'h6,
    CMD_SET_GP     = 4'h7,
    CMD_CLR_GP     = 4'h8
  } cmd_e;

  // Erase pin handling states
  typedef enum logic [1:0] {
    ERS_IDLE,
    ERS_WAIT,
    ERS_CLEARED
  } erase_state_e;

endpackage

/* File: flash_lock_security_nvm.sv */
// Flash lock region, security and nonvolatile bit control with APB slave
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "flash_lock_consts.svh"

module flash_lock_security_nvm #(
  parameter int unsigned ERASE_MIN_CYCLES = (`ERASE_MIN_MS * `SYS_CLK_KHZ) + 1
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        erase_pin,
  input  wire logic        dbg_req,
  input  wire logic        fastprog_req,
  output logic             dbg_grant,
  output logic             fastprog_grant,
  output logic             bod_enable,
  output logic             bod_reset_enable,
  output logic             irq
);

  // ==========================================================
  // Declarations
  logic [31:0] mode_reg;         // Mode register
  logic [2:0]  status_reg;       // Sticky events
  logic [2:0]  mask_reg;         // Interrupt mask
  logic [7:0]  lock_reg;         // Lock bits per region
  logic        sec_reg;          // Security bit
  logic [1:0]  gp_reg;           // General-purpose nonvolatile bits
  logic        ers_s1_reg;       // Synchroniser stage 1
  logic        ers_s2_reg;       // Synchroniser stage 2
  logic [`ERASE_CNT_W-1:0] ers_cnt_reg; // High-time counter
  flash_lock_pkg::erase_state_e ers_state_reg; // Erase pin state
  logic        ers_hit;          // Qualified erase pulse
  logic        ers_pending_reg;  // Erase pin seen, full erase awaited
  logic        wr_acc;           // Write access phase
  logic        rd_acc;           // Read access phase
  logic [3:0]  cmd_op;           // Command opcode
  logic [7:0]  cmd_arg;          // Command argument
  logic        cmd_go;           // Command write
  logic        locked_hit;       // Command targets locked region
  logic        lock_err;         // Lock error event
  logic        cmd_done;         // Command completed event
  logic        full_erased;      // Full erase completed event

  // Region number of a page number
  function automatic logic [`REGION_BITS-1:0] page_region(input logic [7:0] page);
    page_region = page[`REGION_SHIFT +: `REGION_BITS];
  endfunction

  // Address match helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // Bus decode
  assign wr_acc  = psel && penable && pwrite && clk_en;
  assign rd_acc  = psel && penable && !pwrite && clk_en;
  assign cmd_go  = wr_acc && hit(paddr, `OFS_CMD);
  assign cmd_op  = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
  assign cmd_arg = pwdata[`CMD_ARG_MSB:`CMD_ARG_LSB];

  // Erase or program into a locked region
  assign locked_hit = lock_reg[page_region(cmd_arg)];
  assign lock_err = cmd_go && locked_hit &&
                    ((cmd_op == flash_lock_pkg::CMD_PROG) ||
                     (cmd_op == flash_lock_pkg::CMD_ERASE_PAGE));
  assign full_erased = cmd_go && (cmd_op == flash_lock_pkg::CMD_ERASE_ALL) &&
                       (lock_reg == 8'h00);
  assign cmd_done = cmd_go && !lock_err;

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable &&
                 !(hit(paddr, `OFS_CMD) || hit(paddr, `OFS_MODE) ||
                   hit(paddr, `OFS_STATUS) || hit(paddr, `OFS_MASK) ||
                   hit(paddr, `OFS_NVSTATE) || hit(paddr, `OFS_ACCESS));
    end
  end

  // Read data, registered in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_MODE:    prdata <= mode_reg;
        `OFS_STATUS:  prdata <= {29'h0, status_reg};
        `OFS_MASK:    prdata <= {29'h0, mask_reg};
        `OFS_NVSTATE: prdata <= {21'h0, gp_reg, sec_reg, lock_reg};
        `OFS_ACCESS:  prdata <= {30'h0, fastprog_grant, dbg_grant};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Mode and mask registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_reg <= 32'h0000_0000;
      mask_reg <= 3'h0;
    end else if (wr_acc) begin
      if (hit(paddr, `OFS_MODE)) begin
        mode_reg <= pwdata;
        mask_reg[`ST_LOCK_ERROR_FLAG] <= pwdata[`MODE_LOCK_ERROR_FLAG_EN];
      end
      if (hit(paddr, `OFS_MASK)) begin
        mask_reg <= pwdata[2:0];
      end
    end
  end

  // ==========================================================
  // Sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_reg <= 3'h0;
    end else if (clk_en) begin
      status_reg <= (status_reg &
                     ~((wr_acc && hit(paddr, `OFS_STATUS)) ? pwdata[2:0] : 3'h0)) |
                    {full_erased, cmd_done, lock_err};
    end
  end

  // Interrupt level output
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // Erase pin synchroniser and qualification
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ers_s1_reg <= 1'b0;
      ers_s2_reg <= 1'b0;
    end else if (clk_en) begin
      ers_s1_reg <= erase_pin;
      ers_s2_reg <= ers_s1_reg;
    end
  end

  // High-time counter and state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ers_cnt_reg   <= '0;
      ers_state_reg <= flash_lock_pkg::ERS_IDLE;
    end else if (clk_en) begin
      case (ers_state_reg)
        flash_lock_pkg::ERS_IDLE: begin
          ers_cnt_reg <= '0;
          if (ers_s2_reg) begin
            ers_state_reg <= flash_lock_pkg::ERS_WAIT;
          end
        end
        flash_lock_pkg::ERS_WAIT: begin
          if (!ers_s2_reg) begin
            ers_state_reg <= flash_lock_pkg::ERS_IDLE;
          end else if (ers_cnt_reg == ERASE_MIN_CYCLES[`ERASE_CNT_W-1:0] - 1'b1) begin
            ers_state_reg <= flash_lock_pkg::ERS_CLEARED;
          end else begin
            ers_cnt_reg <= ers_cnt_reg + 1'b1;
          end
        end
        flash_lock_pkg::ERS_CLEARED: begin
          if (!ers_s2_reg) begin
            ers_state_reg <= flash_lock_pkg::ERS_IDLE;
          end
        end
        default: ers_state_reg <= flash_lock_pkg::ERS_IDLE;
      endcase
    end
  end

  assign ers_hit = clk_en && (ers_state_reg == flash_lock_pkg::ERS_WAIT) && ers_s2_reg &&
                   (ers_cnt_reg == ERASE_MIN_CYCLES[`ERASE_CNT_W-1:0] - 1'b1);

  // Independent count of consecutive high samples, for checking only
  logic [`ERASE_CNT_W:0] ers_run_reg; // Saturating run length
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ers_run_reg <= '0;
    end else if (clk_en) begin
      if (!ers_s2_reg) begin
        ers_run_reg <= '0;                 // Low sample restarts the run
      end else if (!(&ers_run_reg)) begin
        ers_run_reg <= ers_run_reg + 1'b1; // Stops at all ones
      end
    end
  end

  // ==========================================================
  // Lock bits
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lock_reg <= 8'h00;
    end else if (ers_hit) begin
      lock_reg <= 8'h00;
    end else if (cmd_go && cmd_op == flash_lock_pkg::CMD_SET_LOCK) begin
      lock_reg[page_region(cmd_arg)] <= 1'b1;
    end else if (cmd_go && cmd_op == flash_lock_pkg::CMD_CLR_LOCK) begin
      lock_reg[page_region(cmd_arg)] <= 1'b0;
    end
  end

  // Security bit and pending-erase tracking
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sec_reg         <= 1'b0;
      ers_pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (ers_hit) begin
        ers_pending_reg <= 1'b1;
      end else if (full_erased && ers_pending_reg) begin
        ers_pending_reg <= 1'b0;
        sec_reg         <= 1'b0;
      end else if (cmd_go && cmd_op == flash_lock_pkg::CMD_SET_SEC) begin
        sec_reg <= 1'b1;
      end
    end
  end

  // General-purpose nonvolatile bits
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      gp_reg <= 2'h0;
    end else if (ers_hit) begin
      gp_reg <= 2'h0;
    end else if (cmd_go && cmd_op == flash_lock_pkg::CMD_SET_GP) begin
      gp_reg[cmd_arg[0]] <= 1'b1;
    end else if (cmd_go && cmd_op == flash_lock_pkg::CMD_CLR_GP) begin
      gp_reg[cmd_arg[0]] <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs from flip-flops
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dbg_grant        <= 1'b0;
      fastprog_grant   <= 1'b0;
      bod_enable       <= 1'b0;
      bod_reset_enable <= 1'b0;
    end else if (clk_en) begin
      dbg_grant        <= dbg_req && !sec_reg;
      fastprog_grant   <= fastprog_req && !sec_reg;
      bod_enable       <= gp_reg[0];
      bod_reset_enable <= gp_reg[1];
    end
  end

  // ==========================================================
  // Assertions
  property p_lock_err;
    @(posedge sys_clk) disable iff (!rstn) lock_err |=> status_reg[`ST_LOCK_ERROR_FLAG];
  endproperty
  a_lock_err: assert property (p_lock_err) else $error("lock error not flagged");

  property p_irq;
    @(posedge sys_clk) disable iff (!rstn)
      clk_en && status_reg[`ST_LOCK_ERROR_FLAG] && mask_reg[`ST_LOCK_ERROR_FLAG] |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_set_lock;
    @(posedge sys_clk) disable iff (!rstn)
      cmd_go && cmd_op == flash_lock_pkg::CMD_SET_LOCK && !ers_hit |=> lock_reg != 8'h00;
  endproperty
  a_set_lock: assert property (p_set_lock) else $error("lock not set");

  property p_erase_locks;
    @(posedge sys_clk) disable iff (!rstn) ers_hit |=> lock_reg == 8'h00 && gp_reg == 2'h0;
  endproperty
  a_erase_locks: assert property (p_erase_locks) else $error("erase did not clear");

  property p_sec_block;
    @(posedge sys_clk) disable iff (!rstn) clk_en && sec_reg |=> !dbg_grant && !fastprog_grant;
  endproperty
  a_sec_block: assert property (p_sec_block) else $error("access while secured");

  property p_open;
    @(posedge sys_clk) disable iff (!rstn) clk_en && !sec_reg && dbg_req |=> dbg_grant;
  endproperty
  a_open: assert property (p_open) else $error("access refused while open");

  property p_sec_set;
    @(posedge sys_clk) disable iff (!rstn) $rose(sec_reg) |-> $past(cmd_go);
  endproperty
  a_sec_set: assert property (p_sec_set) else $error("security set without command");

  property p_bod;
    @(posedge sys_clk) disable iff (!rstn) clk_en |=> bod_enable == $past(gp_reg[0]);
  endproperty
  a_bod: assert property (p_bod) else $error("brownout enable mismatch");

  property p_bodr;
    @(posedge sys_clk) disable iff (!rstn) clk_en |=> bod_reset_enable == $past(gp_reg[1]);
  endproperty
  a_bodr: assert property (p_bodr) else $error("brownout reset mismatch");

  property p_ers_qual;
    @(posedge sys_clk) disable iff (!rstn) ers_hit |-> ers_run_reg >= ERASE_MIN_CYCLES;
  endproperty
  a_ers_qual: assert property (p_ers_qual) else $error("erase qualified while low");

  property p_gp_set;
    @(posedge sys_clk) disable iff (!rstn)
      cmd_go && cmd_op == flash_lock_pkg::CMD_SET_GP && !ers_hit |=> gp_reg[$past(cmd_arg[0])];
  endproperty
  a_gp_set: assert property (p_gp_set) else $error("general bit not set");

  property p_sec_clear;
    @(posedge sys_clk) disable iff (!rstn)
      $fell(sec_reg) && $past(rstn) |-> $past(full_erased) && $past(ers_pending_reg);
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("security cleared without erase");

  c_lock_err: cover property (@(posedge sys_clk) disable iff (!rstn) lock_err);
  c_sec: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(sec_reg));
  c_ers: cover property (@(posedge sys_clk) disable iff (!rstn) ers_hit);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(irq));
  c_gp_both: cover property (@(posedge sys_clk) disable iff (!rstn) gp_reg == 2'h3);

endmodule
`default_nettype wire

/* File: flash_lock_security_nvm_tb.sv */
// Self-checking testbench for the flash lock, security and nonvolatile bit block
`timescale 1ns/100ps
`default_nettype none
`include "flash_lock_consts.svh"

module flash_lock_security_nvm_tb;
  // ==========================================================
  // Signals and bookkeeping
  typedef struct {
    logic [31:0] cmd;  // Command word
    logic [31:0] nv;   // Expected nonvolatile state
  } row_s;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        erase_pin = 1'b0;
  logic        dbg_req = 1'b0;
  logic        fastprog_req = 1'b0;
  logic        dbg_grant;
  logic        fastprog_grant;
  logic        bod_enable;
  logic        bod_reset_enable;
  logic        irq;
  int          bad_count = 0;
  int          checks = 0;
  logic [31:0] rd;
  logic        er;
  row_s        rows [8];

  // ==========================================================
  // Device under test, short erase qualification
  flash_lock_security_nvm #(.ERASE_MIN_CYCLES(8)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .erase_pin(erase_pin), .dbg_req(dbg_req),
    .fastprog_req(fastprog_req), .dbg_grant(dbg_grant), .fastprog_grant(fastprog_grant),
    .bod_enable(bod_enable), .bod_reset_enable(bod_reset_enable), .irq(irq));

  // Clock, 100 ns period
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] cw(flash_lock_pkg::cmd_e op, logic [7:0] arg);
    return {16'h0000, arg, 4'h0, op};
  endfunction

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One comparison
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      bad_count++;
      finish_test();
    end
  endtask

  // Command, then poll status for done or lock error, then clear status
  task automatic do_cmd(logic [31:0] c, output logic [31:0] st);
    int n;
    apb(1'b1, `OFS_CMD, c);
    for (n = 0; n < 50; n++) begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      if (rd[1:0] !== 2'b00) break;
    end
    st = rd;
    if (n == 50) begin
      bad_count++;
      finish_test();
    end
    apb(1'b1, `OFS_STATUS, 32'h0000_0007);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] st;
    rows[0] = '{cw(flash_lock_pkg::CMD_SET_LOCK, 8'h00), 32'h0000_0001};
    rows[1] = '{cw(flash_lock_pkg::CMD_SET_LOCK, 8'he0), 32'h0000_0081};
    rows[2] = '{cw(flash_lock_pkg::CMD_SET_LOCK, 8'h3f), 32'h0000_0083};
    rows[3] = '{cw(flash_lock_pkg::CMD_CLR_LOCK, 8'h20), 32'h0000_0081};
    rows[4] = '{cw(flash_lock_pkg::CMD_SET_GP, 8'h00), 32'h0000_0281};
    rows[5] = '{cw(flash_lock_pkg::CMD_SET_GP, 8'h01), 32'h0000_0681};
    rows[6] = '{cw(flash_lock_pkg::CMD_CLR_GP, 8'h00), 32'h0000_0481};
    rows[7] = '{cw(flash_lock_pkg::CMD_SET_GP, 8'h00), 32'h0000_0681};
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    // Reset state
    apb(1'b0, `OFS_NVSTATE, 32'h0);
    chk("nv_reset", 32'h0, rd);
    chk("irq_reset", 32'h0, {31'h0, irq});
    $display("test reset done");
    // Table of lock and general bit commands
    foreach (rows[i]) begin
      do_cmd(rows[i].cmd, st);
      apb(1'b0, `OFS_NVSTATE, 32'h0);
      chk("nv_row", rows[i].nv, rd);
      chk("bod", {30'h0, rows[i].nv[10:9]}, {30'h0, bod_reset_enable, bod_enable});
    end
    $display("test table done");
    // Locked program and erase, interrupt disabled then enabled
    do_cmd(cw(flash_lock_pkg::CMD_PROG, 8'h45), st);
    chk("prog_free", 32'h0, {31'h0, st[0]});
    apb(1'b1, `OFS_CMD, cw(flash_lock_pkg::CMD_PROG, 8'he1));
    repeat (3) apb(1'b0, `OFS_STATUS, 32'h0);
    chk("lock_error_flag", 32'h1, {31'h0, rd[0]});
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b1, `OFS_MODE, 32'h0000_0001);
    apb(1'b0, `OFS_ACCESS, 32'h0);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, `OFS_STATUS, 32'h0000_0007);
    apb(1'b0, `OFS_ACCESS, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    apb(1'b1, `OFS_CMD, cw(flash_lock_pkg::CMD_ERASE_PAGE, 8'h1f));
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("erase_lock", 32'h1, {31'h0, rd[0]});
    chk("erase_abort", 32'h0, {31'h0, rd[1]});
    chk("irq_erase", 32'h1, {31'h0, irq});
    apb(1'b1, `OFS_STATUS, 32'h0000_0007);
    apb(1'b0, `OFS_NVSTATE, 32'h0);
    chk("nv_kept", 32'h0000_0681, rd);
    $display("test lock error done");
    // Unmapped addresses
    apb(1'b0, 12'h018, 32'h0);
    chk("err_rd", 32'h1, {31'h0, er});
    chk("rd_zero", 32'h0, rd);
    apb(1'b1, 12'h0f0, 32'hffff_ffff);
    chk("err_wr", 32'h1, {31'h0, er});
    $display("test unmapped done");
    // Security, erase pin, full erase
    dbg_req <= 1'b1;
    fastprog_req <= 1'b1;
    apb(1'b0, `OFS_ACCESS, 32'h0);
    chk("acc_open", 32'h3, rd);
    do_cmd(cw(flash_lock_pkg::CMD_SET_SEC, 8'h00), st);
    apb(1'b0, `OFS_ACCESS, 32'h0);
    chk("acc_sec", 32'h0, rd);
    chk("grant_sec", 32'h0, {30'h0, fastprog_grant, dbg_grant});
    @(posedge sys_clk) erase_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    erase_pin <= 1'b0;
    repeat (20) @(posedge sys_clk);
    apb(1'b0, `OFS_NVSTATE, 32'h0);
    chk("nv_short", 32'h0000_0781, rd);
    erase_pin <= 1'b1;
    repeat (20) @(posedge sys_clk);
    erase_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, `OFS_NVSTATE, 32'h0);
    chk("nv_erased", 32'h0000_0100, rd);
    chk("bod_erased", 32'h0, {30'h0, bod_reset_enable, bod_enable});
    do_cmd(cw(flash_lock_pkg::CMD_ERASE_ALL, 8'h00), st);
    apb(1'b0, `OFS_NVSTATE, 32'h0);
    chk("nv_unsec", 32'h0, rd);
    apb(1'b0, `OFS_ACCESS, 32'h0);
    chk("acc_reopen", 32'h3, rd);
    chk("grant_open", 32'h3, {30'h0, fastprog_grant, dbg_grant});
    $display("test security done");
    // Clock enable low freezes the grant, high lets it follow again
    clk_en <= 1'b0;
    dbg_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("grant_frozen", 32'h1, {31'h0, dbg_grant});
    clk_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("grant_thawed", 32'h0, {31'h0, dbg_grant});
    $display("test clock enable done");
    finish_test();
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
